// File: core/pcs_apb.sv
`timescale 1ns/100ps
module pcs_apb (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  output logic             wr_o,
  output logic             rd_o,
  output logic             pready_o
);
  typedef struct packed {
    pcs_pkg::pcs_bus_st_t state;
  } pcs_apb_st_t;

  pcs_apb_st_t st;
  pcs_apb_st_t next_st;

  // Fixed one wait state: access is committed when ready goes high
  always_comb begin
    next_st = st;
    case (st.state)
      pcs_pkg::PCS_IDLE: begin
        if (psel_i && penable_i) begin
          next_st.state = pcs_pkg::PCS_ACCESS;
        end
      end
      pcs_pkg::PCS_ACCESS: begin
        next_st.state = pcs_pkg::PCS_DONE;
      end
      pcs_pkg::PCS_DONE: begin
        next_st.state = pcs_pkg::PCS_IDLE;
      end
      default: begin
        next_st.state = pcs_pkg::PCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st.state <= pcs_pkg::PCS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign pready_o = (st.state == pcs_pkg::PCS_ACCESS);
  assign wr_o     = pready_o && pwrite_i;
  assign rd_o     = pready_o && !pwrite_i;
endmodule : pcs_apb

// File: core/pcs_counter.sv
`timescale 1ns/100ps
`include "pcs_defs.svh"
module pcs_counter (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       clear_i,
  input  wire logic       inc_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       evt_en_i,
  output logic      [7:0] count_o,
  output logic            ovf_o
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       ovf;
  } pcs_cnt_st_t;

  pcs_cnt_st_t st;
  pcs_cnt_st_t next_st;

  always_comb begin
    next_st     = st;
    next_st.ovf = 1'b0;
    if (clear_i) begin
      next_st.cnt = `PCS_CNT_RESET;
    end else if (wr_i) begin
      next_st.cnt = wdata_i;
    end else if (inc_i) begin
      next_st.cnt = st.cnt + 8'h01;
      next_st.ovf = (st.cnt == 8'hFF) && evt_en_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count_o = st.cnt;
  assign ovf_o   = st.ovf;

  a_cnt_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    (inc_i && !clear_i && !wr_i && st.cnt == 8'hFF) |=> st.cnt == 8'h00)
    else $error("counter did not wrap");
  a_cnt_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    clear_i |=> st.cnt == 8'h00)
    else $error("counter not cleared");
  a_ovf_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    st.ovf |=> !st.ovf)
    else $error("overflow longer than one cycle");
  c_cnt_wrap: cover property (@(posedge clk_i) disable iff (rst_i) st.ovf);
endmodule : pcs_counter

// File: core/pcs_defs.svh
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH
// Register byte addresses
`define PCS_ADDR_CTRL   12'h000
`define PCS_ADDR_STALL  12'h004
`define PCS_ADDR_EXC    12'h008
`define PCS_ADDR_SLEEP  12'h00C
`define PCS_ADDR_LSU    12'h010
`define PCS_ADDR_FOLD   12'h014
`define PCS_ADDR_PCSR   12'h018
// Control register fields (event enables at bits 0..4)
`define PCS_CTRL_ABSENT_BIT 31
`define PCS_NUM_CNT     5
`define PCS_CNT_W       8
`define PCS_CNT_RESET   8'h00
`define PCS_CTRL_RESET  5'h00
// Implementation options
`define PCS_HAS_PRF     1'b1
`define PCS_HAS_FOLD    1'b1
`define PCS_HAS_PCSR    1'b1
`define PCS_ABSENT_READ 32'h00000000
`endif

// File: core/pcs_pkg.sv
package pcs_pkg;
  typedef enum logic [2:0] {
    PCS_IDLE   = 3'b001,
    PCS_ACCESS = 3'b010,
    PCS_DONE   = 3'b100
  } pcs_bus_st_t;

  typedef enum logic [2:0] {
    PCS_CNT_STALL = 3'h0,
    PCS_CNT_EXC   = 3'h1,
    PCS_CNT_SLEEP = 3'h2,
    PCS_CNT_LSU   = 3'h3,
    PCS_CNT_FOLD  = 3'h4
  } pcs_cnt_idx_t;
endpackage : pcs_pkg

// File: core/pcs_top.sv
`timescale 1ns/100ps
`include "pcs_defs.svh"
module pcs_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        multi_cycle_i,
  input  wire logic        fetch_stall_i,
  input  wire logic        lsu_extra_i,
  input  wire logic        exception_i,
  input  wire logic        sleeping_i,
  input  wire logic        folded_i,
  input  wire logic        retire_i,
  input  wire logic [31:0] retire_addr_i,
  output logic      [4:0]  overflow_evt_o
);
  typedef struct packed {
    logic [4:0]  evt_en;
    logic [31:0] pc_sample;
    logic [31:0] rdata;
    logic        ready;
    logic [4:0]  ovf;
  } pcs_top_st_t;

  pcs_top_st_t st;
  pcs_top_st_t next_st;

  logic        wr_commit;
  logic        rd_commit;
  logic        bus_ready;
  logic [4:0]  cnt_inc;
  logic [4:0]  cnt_clear;
  logic [4:0]  cnt_wr;
  logic [4:0]  cnt_ovf;
  logic [7:0]  cnt_val [0:4];
  logic        ctrl_wr;

  function automatic logic [2:0] addr_to_idx(input logic [11:0] a);
    case (a)
      `PCS_ADDR_STALL: addr_to_idx = 3'h0;
      `PCS_ADDR_EXC:   addr_to_idx = 3'h1;
      `PCS_ADDR_SLEEP: addr_to_idx = 3'h2;
      `PCS_ADDR_LSU:   addr_to_idx = 3'h3;
      `PCS_ADDR_FOLD:  addr_to_idx = 3'h4;
      default:         addr_to_idx = 3'h7;
    endcase
  endfunction : addr_to_idx

  pcs_apb u_apb (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .wr_o      (wr_commit),
    .rd_o      (rd_commit),
    .pready_o  (bus_ready)
  );

  assign ctrl_wr = wr_commit && (paddr_i == `PCS_ADDR_CTRL);

  assign cnt_inc[0] = (multi_cycle_i || fetch_stall_i) && !lsu_extra_i;
  assign cnt_inc[1] = exception_i;
  assign cnt_inc[2] = sleeping_i;
  assign cnt_inc[3] = lsu_extra_i;
  assign cnt_inc[4] = folded_i && `PCS_HAS_FOLD;

  genvar g;
  generate
    for (g = 0; g < `PCS_NUM_CNT; g++) begin : g_cnt
      assign cnt_clear[g] = ctrl_wr && pwdata_i[g] && !st.evt_en[g];
      assign cnt_wr[g] = wr_commit && `PCS_HAS_PRF
                         && (addr_to_idx(paddr_i) == 3'(g))
                         && ((g != 4) || `PCS_HAS_FOLD);
      pcs_counter u_cnt (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .clear_i  (cnt_clear[g]),
        .inc_i    (cnt_inc[g] && `PCS_HAS_PRF),
        .wr_i     (cnt_wr[g]),
        .wdata_i  (pwdata_i[7:0]),
        .evt_en_i (st.evt_en[g]),
        .count_o  (cnt_val[g]),
        .ovf_o    (cnt_ovf[g])
      );
    end
  endgenerate

  always_comb begin
    next_st       = st;
    next_st.ready = bus_ready;
    next_st.ovf   = cnt_ovf;
    if (ctrl_wr) begin
      next_st.evt_en = pwdata_i[4:0];
    end
    if (retire_i && `PCS_HAS_PCSR) begin
      next_st.pc_sample = {retire_addr_i[31:1], 1'b0};
    end
    if (rd_commit) begin
      next_st.rdata = 32'h00000000;
      case (paddr_i)
        `PCS_ADDR_CTRL: begin
          next_st.rdata = {!`PCS_HAS_PRF, 26'h0000000, st.evt_en};
        end
        `PCS_ADDR_PCSR: begin
          next_st.rdata = `PCS_HAS_PCSR ? st.pc_sample : 32'h00000000;
        end
        default: begin
          if (addr_to_idx(paddr_i) != 3'h7) begin
            next_st.rdata = `PCS_HAS_PRF
              ? {24'h000000, cnt_val[addr_to_idx(paddr_i)]}
              : `PCS_ABSENT_READ;
            if (addr_to_idx(paddr_i) == 3'h4 && !`PCS_HAS_FOLD) begin
              next_st.rdata = 32'h00000000;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Data and ready are registered, so the answer lags commit by one cycle
  assign prdata_o       = st.rdata;
  assign pready_o       = st.ready;
  assign pslverr_o      = 1'b0;
  assign overflow_evt_o = st.ovf;

  a_stall_no_lsu: assert property (@(posedge clk_i) disable iff (rst_i)
    (lsu_extra_i && !cnt_clear[0] && !cnt_wr[0])
      |=> cnt_val[0] == $past(cnt_val[0]))
    else $error("stall counter counted a load/store cycle");
  a_exc_count: assert property (@(posedge clk_i) disable iff (rst_i)
    (exception_i && !cnt_clear[1] && !cnt_wr[1])
      |=> cnt_val[1] == $past(cnt_val[1]) + 8'h01)
    else $error("exception counter missed a cycle");
  a_sleep_count: assert property (@(posedge clk_i) disable iff (rst_i)
    (sleeping_i && !cnt_clear[2] && !cnt_wr[2])
      |=> cnt_val[2] == $past(cnt_val[2]) + 8'h01)
    else $error("sleep counter missed a cycle");
  a_lsu_count: assert property (@(posedge clk_i) disable iff (rst_i)
    (lsu_extra_i && !cnt_clear[3] && !cnt_wr[3])
      |=> cnt_val[3] == $past(cnt_val[3]) + 8'h01)
    else $error("load/store counter missed a cycle");
  a_fold_count: assert property (@(posedge clk_i) disable iff (rst_i)
    (folded_i && !cnt_clear[4] && !cnt_wr[4])
      |=> cnt_val[4] == $past(cnt_val[4]) + 8'h01)
    else $error("folded counter missed an instruction");
  a_pc_bit0: assert property (@(posedge clk_i) disable iff (rst_i)
    st.pc_sample[0] == 1'b0)
    else $error("sample bit 0 set");
  a_pc_sample: assert property (@(posedge clk_i) disable iff (rst_i)
    retire_i |=> st.pc_sample[31:1] == $past(retire_addr_i[31:1]))
    else $error("sample not taken");
  a_rsvd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_commit && addr_to_idx(paddr_i) != 3'h7)
      |=> prdata_o[31:8] == 24'h000000)
    else $error("reserved bits not zero");
  a_stall_count: assert property (@(posedge clk_i) disable iff (rst_i)
    (fetch_stall_i && !lsu_extra_i && !cnt_clear[0] && !cnt_wr[0])
      |=> cnt_val[0] == $past(cnt_val[0]) + 8'h01)
    else $error("stall counter missed a cycle");
  a_ovf_to_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    (cnt_ovf != 5'h00) |=> overflow_evt_o == $past(cnt_ovf))
    else $error("overflow not forwarded");
  c_read: cover property (@(posedge clk_i) disable iff (rst_i) rd_commit);
  c_clear: cover property (@(posedge clk_i) disable iff (rst_i)
    cnt_clear != 5'h00);
  c_lsu_stall: cover property (@(posedge clk_i) disable iff (rst_i)
    lsu_extra_i && multi_cycle_i);
endmodule : pcs_top

// File: test/pcs_core_model.sv
`timescale 1ns/100ps
// Pipeline status source: per-cycle qualifier levels and retire pulses
module pcs_core_model (
  input  wire logic        clk_i,
  input  wire logic        en_i,
  input  wire logic [31:0] rnd_i,
  output logic      [5:0]  qual_o,
  output logic             retire_o,
  output logic      [31:0] addr_o
);
  initial begin
    qual_o = 6'h00;
    retire_o = 1'b0;
    addr_o = 32'h00000000;
  end
  // Address is inverted while idle so a stale value is never mistaken
  always @(posedge clk_i) begin
    qual_o   <= en_i ? rnd_i[5:0] : 6'h00;
    retire_o <= en_i & rnd_i[6];
    addr_o   <= en_i ? {rnd_i[15:0], rnd_i[31:16]} : ~addr_o;
  end
endmodule : pcs_core_model

// File: test/test_profiling_counters_pc_sampler.sv
`timescale 1ns/100ps
`include "pcs_defs.svh"
module test_profiling_counters_pc_sampler;
  logic        clk_i, rst_i, psel_i, penable_i, pwrite_i, en, pready_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rnd, rd, exp_pc, ret_addr;
  logic [5:0]  qual;
  logic [4:0]  overflow_evt_o, ctrl;
  logic        retire;
  int          n_mismatch, samples_checked, cnt[5], ovf_exp[5], ovf_got[5];

  pcs_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(), .multi_cycle_i(qual[0]), .fetch_stall_i(qual[1]),
    .lsu_extra_i(qual[2]), .exception_i(qual[3]), .sleeping_i(qual[4]),
    .folded_i(qual[5]), .retire_i(retire), .retire_addr_i(ret_addr),
    .overflow_evt_o(overflow_evt_o));
  pcs_core_model u_core (.clk_i(clk_i), .en_i(en), .rnd_i(rnd),
    .qual_o(qual), .retire_o(retire), .addr_o(ret_addr));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) rnd <= xs(rnd);

  // Reference counters, fed by what the design sees at each edge
  always @(posedge clk_i) begin : core_ref
    logic [4:0] inc;
    inc = {qual[5], qual[2], qual[4], qual[3], (qual[0] | qual[1]) & ~qual[2]};
    if (!rst_i) begin
      for (int i = 0; i < 5; i++) begin
        ovf_got[i] += overflow_evt_o[i];
        if (inc[i]) begin
          if (cnt[i] == 255 && ctrl[i]) ovf_exp[i]++;
          cnt[i] = (cnt[i] + 1) % 256;
        end
      end
      if (retire) exp_pc = ret_addr & 32'hFFFFFFFE;
    end
  end

  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (pready_o !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
    rd = prdata_o;
    psel_i <= 1'b0; penable_i <= 1'b0;
    if (w && a == `PCS_ADDR_CTRL) begin
      for (int i = 0; i < 5; i++) if (d[i] && !ctrl[i]) cnt[i] = 0;
      ctrl = d[4:0];
    end else if (w && a >= 12'h004 && a <= 12'h014) cnt[int'(a >> 2) - 1] = d[7:0];
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk($sformatf("reg %h", a), e, rd);
  endtask : rdchk

  initial begin
    rst_i = 1'b1; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
    paddr_i = 12'h000; pwdata_i = 32'h00000000; en = 1'b0;
    rnd = 32'h8EE5A822; ctrl = 5'h00; exp_pc = 32'h00000000;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(`PCS_ADDR_CTRL, 32'h00000000);
    for (int i = 1; i <= 5; i++) rdchk(12'(4 * i), 32'h00000000);
    apb(1'b1, 12'h01C, 32'hFFFFFFFF);
    rdchk(12'h01C, 32'h00000000);
    for (int p = 0; p < 2; p++) begin
      for (int i = 1; i <= 5; i++) begin
        apb(1'b1, 12'(4 * i), 32'hFFFFFF5A);
        rdchk(12'(4 * i), 32'h0000005A);
      end
      apb(1'b1, `PCS_ADDR_CTRL, 32'h0000001F);
      for (int i = 1; i <= 5; i++) rdchk(12'(4 * i), 32'h00000000);
      for (int i = 1; i <= 5; i++) apb(1'b1, 12'(4 * i), 32'h000000F0);
      en <= 1'b1;
      repeat (120) @(posedge clk_i);
      en <= 1'b0;
      repeat (6) @(posedge clk_i);
      for (int i = 1; i <= 5; i++) rdchk(12'(4 * i), cnt[i - 1]);
      rdchk(`PCS_ADDR_PCSR, exp_pc);
      apb(1'b1, `PCS_ADDR_PCSR, 32'h12345679);
      rdchk(`PCS_ADDR_PCSR, exp_pc);
      apb(1'b1, `PCS_ADDR_CTRL, 32'h00000000);
    end
    for (int i = 0; i < 5; i++) chk("overflow", ovf_exp[i], ovf_got[i]);
    report_and_stop();
  end
endmodule : test_profiling_counters_pc_sampler
